//--- sfm_ctrl.sv
// Command decode, mode, reset and status control of the serial flash
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - Opcode 38h switches to four-bit instructions
// - Quad mode refuses 03h, 3Bh, BBh, 32h
// - FFh frame returns device to one-bit mode
// - FFh does nothing in one-bit mode without enhancement
// - FFh leaves enhancement first, then quad
// - Reset needs 66h then 99h frame
// - Reset clears status to 00h, ready
// - Reset aborts program/erase; 28us recovery after erase only
// - Reset works busy, quad, enhanced; returns single
// - 06h sets latch; latch gates writes
// - 04h clears latch, leaves OTP mode
// - Latch clears when write cycles finish
// - 05h reads status anytime, repeating
// - Status byte bit layout as defined
// - Busy bit high during write cycles
// - Latch low rejects writes and erases
// - Block protect bits guard program, erase
// - Protect bit plus low pin locks status in one-bit mode
// - Pin disable bit ignores protect pin
// - OTP status write sets lock bit; reset clears it
// - Opcode: eight clocks single, two quad
// - Status write keeps busy and latch
module sfm_ctrl
	import sfm_pkg::*;
#(
	parameter int STATUS_WRITE_CYCLES = 1000,  // Self-timed status write
	parameter int PROGRAM_CYCLES      = 2000,  // Self-timed page program
	parameter int ERASE_CYCLES        = 4000,  // Self-timed erase
	parameter logic [7:0] STATUS_INIT = 8'h00  // Non-volatile bits at power-up
) (
	input  wire logic       clock,          // System clock
	input  wire logic       arst_n,         // Asynchronous reset, active low
	input  wire logic       serialClock,    // Link clock from the host
	input  wire logic       chipSelN,       // Frame select, active low
	input  wire logic [3:0] dqIn,           // Data pins in; dqIn[2] is protect pin
	output logic      [3:0] dqOut,          // Data pins out
	output logic      [3:0] dqOe,           // Data pin enables
	input  wire logic       enhanceActive,  // Read engine is in enhancement mode
	output logic            enhanceRelease, // Pulse: leave enhancement mode
	output logic            opStart,        // Pulse: accepted program/erase/read
	output logic      [7:0] opCode,         // Opcode that opStart launched
	output logic            opAbort,        // Pulse: running cycle aborted
	output logic            quadMode,       // Four-bit instruction mode
	output logic            otpMode,        // One-time-programmable mode
	output logic            deviceReady,    // Low during reset recovery
	output logic      [7:0] statusByte      // Status byte as held
);

	localparam int CNT_W = 24; // Cycle counter width

	// Refuse counts the counter cannot hold
	if (STATUS_WRITE_CYCLES < 1 || PROGRAM_CYCLES < 1 || ERASE_CYCLES < 1 ||
		STATUS_WRITE_CYCLES >= 2**CNT_W || PROGRAM_CYCLES >= 2**CNT_W ||
		ERASE_CYCLES >= 2**CNT_W) begin : g_check
		$error("sfm_ctrl cycle counts out of range");
	end

	// ****************************************************************
	// Reset release and pin synchronisers
	// ****************************************************************
	logic [1:0] rstPipe_q;  // Reset release stages
	logic       rst_n;      // Released reset for the system domain
	logic [1:0] pinSync;    // Synchronised chip select and protect pin

	// Release reset through two flops
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rstPipe_q <= 2'h0;
		end else begin
			rstPipe_q <= {rstPipe_q[0], 1'b1};
		end
	end
	assign rst_n = rstPipe_q[1];

	// Chip select idles high, protect pin idles high
	sfm_sync #(
		.WIDTH       (2),
		.RESET_LEVEL (1'b1)
	) u_pin_sync (
		.clock  (clock),
		.arst_n (rst_n),
		.din    ({dqIn[2], chipSelN}),
		.dout   (pinSync)
	);

	// ****************************************************************
	// Link domain: opcode and data shift
	// ****************************************************************
	typedef struct packed {
		logic [4:0] bitCount;  // Bits taken in this frame
		logic       overLong;  // More than opcode plus data byte
		logic [7:0] shiftIn;   // Incoming bits
		logic [7:0] opcode;    // Opcode of the frame
		logic [7:0] dataByte;  // First data byte
	} sfm_link_type;

	typedef struct packed {
		logic [3:0] dqOut;     // Driven data
		logic [3:0] dqOe;      // Driven enables
	} sfm_drive_type;

	sfm_link_type  link_q;
	sfm_link_type  link_d;
	sfm_drive_type drive_q;
	sfm_drive_type drive_d;
	logic          freshFrame_q; // First edge of a new frame is pending
	logic          linkClear;    // Idle link: drop drive
	logic          viewQuad;     // Quad mode as seen by the link
	logic [7:0]    viewStatus;   // Status as seen by the link
	logic          readingStatus;

	// Marks a new frame; set while chip select is high
	always_ff @(posedge serialClock or posedge chipSelN) begin
		if (chipSelN) begin
			freshFrame_q <= 1'b1;
		end else begin
			freshFrame_q <= 1'b0;
		end
	end

	// Shift bits in; one bit or one nibble per edge
	always_comb begin
		logic [4:0] base;
		logic [4:0] step;
		logic [4:0] sum;
		logic [7:0] shifted;
		base    = freshFrame_q ? 5'h00 : link_q.bitCount;
		step    = viewQuad ? STEP_QUAD : STEP_SINGLE;
		sum     = base + step;
		shifted = viewQuad ? {link_q.shiftIn[3:0], dqIn} : {link_q.shiftIn[6:0], dqIn[0]};
		link_d         = link_q;
		link_d.shiftIn = shifted;
		if (freshFrame_q) begin
			link_d.overLong = 1'b0;
		end
		if (base >= DATA_END_BITS) begin
			// Past the data byte: keep the position in the byte only
			link_d.bitCount = {2'b10, sum[2:0]};
			link_d.overLong = 1'b1;
		end else begin
			link_d.bitCount = sum;
		end
		if (sum == OPCODE_BITS) begin
			link_d.opcode = shifted;
		end
		if (sum == DATA_END_BITS && base < DATA_END_BITS) begin
			link_d.dataByte = shifted;
		end
	end

	// Link registers; held between frames for the system side
	always_ff @(posedge serialClock or negedge arst_n) begin
		if (!arst_n) begin
			link_q <= '0;
		end else begin
			link_q <= link_d;
		end
	end

	// Status bytes go out while the opcode is the status read
	assign readingStatus = !freshFrame_q && link_q.bitCount >= OPCODE_BITS &&
		link_q.opcode == OP_STATUS_READ;
	assign linkClear = !arst_n || chipSelN;

	// Choose the bit or nibble to drive after each rising edge
	always_comb begin
		drive_d = '0;
		if (readingStatus) begin
			if (viewQuad) begin
				drive_d.dqOut = link_q.bitCount[2] ? viewStatus[3:0] : viewStatus[7:4];
				drive_d.dqOe  = 4'hf;
			end else begin
				// The byte repeats as the count wraps
				drive_d.dqOut[1] = viewStatus[3'h7 - link_q.bitCount[2:0]];
				drive_d.dqOe     = 4'h2;
			end
		end
	end

	// Change outputs on the falling edge; released when deselected
	always_ff @(negedge serialClock or posedge linkClear) begin
		if (linkClear) begin
			drive_q <= '0;
		end else begin
			drive_q <= drive_d;
		end
	end

	assign dqOut = drive_q.dqOut;
	assign dqOe  = drive_q.dqOe;

	// ****************************************************************
	// System domain: command execution at frame end
	// ****************************************************************
	typedef struct packed {
		logic              csPrev;        // Synchronised chip select, one cycle old
		logic [7:0]        status;        // Status byte
		logic              quad;          // Four-bit instruction mode
		logic              otp;           // One-time-programmable mode
		logic              armed;         // Software reset armed
		sfm_cycle_type     cycle;         // Running self-timed cycle
		logic [CNT_W-1:0]  cycleCount;    // Cycles left
		logic [10:0]       recovery;      // Reset recovery left
		logic [7:0]        viewStatus;    // Copy for the link, frozen in frames
		logic              viewQuad;      // Copy for the link, frozen in frames
		logic              enhanceRelease;
		logic              opStart;
		logic [7:0]        opCode;
		logic              opAbort;
		logic              ready;
	} sfm_sys_type;

	sfm_sys_type sys_q;
	sfm_sys_type sys_d;

	assign viewQuad   = sys_q.viewQuad;
	assign viewStatus = sys_q.viewStatus;

	// Decode the finished frame and run the self-timed cycles
	always_comb begin
		logic       frameEnd;
		logic       complete;
		logic       exactData;
		logic [7:0] op;
		logic [3:0] protect;
		logic       hwLocked;
		logic       isProgram;
		logic       isErase;
		logic       isChip;
		logic       isRead;
		logic       blocked;
		frameEnd  = pinSync[0] && !sys_q.csPrev;
		complete  = link_q.bitCount >= OPCODE_BITS || link_q.overLong;
		exactData = link_q.bitCount == DATA_END_BITS && !link_q.overLong;
		op        = link_q.opcode;
		protect   = sys_q.status[STAT_BP_HI:STAT_BP_LO];
		// Pin disable and quad mode both take the protect pin away
		hwLocked  = sys_q.status[STAT_PROTECT] && !pinSync[1] &&
			!sys_q.status[STAT_PIN_DIS] && !sys_q.quad;
		isProgram = op == OP_PAGE_PROGRAM || op == OP_QUAD_PROGRAM;
		isChip    = op == OP_CHIP_ERASE_A || op == OP_CHIP_ERASE_B;
		isErase   = op == OP_SECTOR_ERASE || op == OP_HALF_ERASE ||
			op == OP_BLOCK_ERASE || isChip;
		isRead    = op == OP_READ_PLAIN || op == OP_READ_FAST || op == OP_READ_DUAL_OUT ||
			op == OP_READ_DUAL_IO || op == OP_READ_QUAD_IO;
		// Commands refused in four-bit mode
		blocked   = sys_q.quad && (op == OP_READ_PLAIN || op == OP_READ_DUAL_OUT ||
			op == OP_READ_DUAL_IO || op == OP_QUAD_PROGRAM);

		sys_d                = sys_q;
		sys_d.csPrev         = pinSync[0];
		sys_d.enhanceRelease = 1'b0;
		sys_d.opStart        = 1'b0;
		sys_d.opAbort        = 1'b0;
		sys_d.ready          = sys_q.recovery == 11'h000;

		// Freeze the link copies while a frame is open
		if (pinSync[0]) begin
			sys_d.viewStatus = sys_q.status;
			sys_d.viewQuad   = sys_q.quad;
		end

		// Count down the running cycle
		if (sys_q.cycle != CYC_NONE) begin
			if (sys_q.cycleCount <= CNT_W'(1)) begin
				sys_d.cycle                = CYC_NONE;
				sys_d.status[STAT_BUSY]    = 1'b0;
				sys_d.status[STAT_WEL]     = 1'b0;
			end else begin
				sys_d.cycleCount = sys_q.cycleCount - CNT_W'(1);
			end
		end
		if (sys_q.recovery != 11'h000) begin
			sys_d.recovery = sys_q.recovery - 11'h001;
		end

		// Only whole opcodes act; a cut frame leaves all state alone
		if (frameEnd && complete && sys_q.recovery == 11'h000) begin
			// Any command but the reset arm itself disarms
			sys_d.armed = 1'b0;
			if (op == OP_RESET_FIRE && sys_q.armed) begin
				// Reset in any mode or during a cycle
				sys_d.status  = STATUS_RESET_VALUE;
				sys_d.quad    = 1'b0;
				sys_d.otp     = 1'b0;
				sys_d.cycle   = CYC_NONE;
				sys_d.opAbort = sys_q.cycle != CYC_NONE;
				sys_d.enhanceRelease = enhanceActive;
				if (sys_q.cycle == CYC_ERASE) begin
					sys_d.recovery = 11'(RECOVERY_CYCLES);
				end
			end else if (op == OP_RESET_ARM) begin
				sys_d.armed = 1'b1;
			end else if (op == OP_STATUS_READ) begin
				// Served by the link side at any time
			end else if (sys_q.cycle != CYC_NONE) begin
				// Busy: everything else is refused
			end else if (op == OP_ENTER_QUAD) begin
				sys_d.quad = 1'b1;
			end else if (op == OP_QUAD_EXIT) begin
				if (enhanceActive) begin
					sys_d.enhanceRelease = 1'b1;
				end else if (sys_q.quad) begin
					sys_d.quad = 1'b0;
				end
				// One-bit mode without enhancement: no effect
			end else if (op == OP_LATCH_SET) begin
				sys_d.status[STAT_WEL] = 1'b1;
			end else if (op == OP_LATCH_CLEAR) begin
				sys_d.status[STAT_WEL] = 1'b0;
				sys_d.otp              = 1'b0;
			end else if (op == OP_ENTER_OTP) begin
				sys_d.otp = 1'b1;
			end else if (op == OP_STATUS_WRITE) begin
				// Needs latch, exact byte, no hardware lock
				if (sys_q.status[STAT_WEL] && exactData && !hwLocked) begin
					if (sys_q.otp) begin
						sys_d.status[STAT_PROTECT] = 1'b1;
					end else begin
						sys_d.status[7:2] = link_q.dataByte[7:2];
					end
					sys_d.status[STAT_BUSY] = 1'b1;
					sys_d.cycle             = CYC_STATUS;
					sys_d.cycleCount        = CNT_W'(STATUS_WRITE_CYCLES);
				end
			end else if (isProgram || isErase) begin
				// Latch, block protect and OTP lock all gate the cycle
				if (sys_q.status[STAT_WEL] && !blocked && protect == 4'h0 &&
					!(sys_q.otp && sys_q.status[STAT_PROTECT])) begin
					sys_d.status[STAT_BUSY] = 1'b1;
					sys_d.cycle      = isProgram ? CYC_PROGRAM : CYC_ERASE;
					sys_d.cycleCount = isProgram ? CNT_W'(PROGRAM_CYCLES) :
						CNT_W'(ERASE_CYCLES);
					sys_d.opStart    = 1'b1;
					sys_d.opCode     = op;
				end
			end else if (isRead && !blocked) begin
				sys_d.opStart = 1'b1;
				sys_d.opCode  = op;
			end
		end
	end

	// Register the whole system state
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sys_q            <= '0;
			sys_q.csPrev     <= 1'b1;
			sys_q.status     <= {STATUS_INIT[7:2], 2'b00};
			sys_q.viewStatus <= {STATUS_INIT[7:2], 2'b00};
			sys_q.cycle      <= CYC_NONE;
			sys_q.ready      <= 1'b1;
		end else begin
			sys_q <= sys_d;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign enhanceRelease = sys_q.enhanceRelease;
	assign opStart        = sys_q.opStart;
	assign opCode         = sys_q.opCode;
	assign opAbort        = sys_q.opAbort;
	assign quadMode       = sys_q.quad;
	assign otpMode        = sys_q.otp;
	assign deviceReady    = sys_q.ready;
	assign statusByte     = sys_q.status;

endmodule
`default_nettype wire

//--- sfm_pkg.sv
// Shared opcodes, status bit layout, reset values and timing counts of the flash control block
package sfm_pkg;

	// ****************************************************************
	// Opcodes
	// ****************************************************************
	localparam logic [7:0] OP_ENTER_QUAD     = 8'h38; // Enter four-bit instruction mode
	localparam logic [7:0] OP_QUAD_EXIT      = 8'hff; // Leave enhancement, then quad mode
	localparam logic [7:0] OP_RESET_ARM      = 8'h66; // Arm the software reset
	localparam logic [7:0] OP_RESET_FIRE     = 8'h99; // Execute the armed reset
	localparam logic [7:0] OP_LATCH_SET      = 8'h06; // Set write enable latch
	localparam logic [7:0] OP_LATCH_CLEAR    = 8'h04; // Clear latch, leave OTP mode
	localparam logic [7:0] OP_STATUS_READ    = 8'h05; // Read status byte
	localparam logic [7:0] OP_STATUS_WRITE   = 8'h01; // Write status byte
	localparam logic [7:0] OP_PAGE_PROGRAM   = 8'h02; // Page program
	localparam logic [7:0] OP_QUAD_PROGRAM   = 8'h32; // Quad input page program
	localparam logic [7:0] OP_SECTOR_ERASE   = 8'h20; // Sector erase
	localparam logic [7:0] OP_HALF_ERASE     = 8'h52; // Half block erase
	localparam logic [7:0] OP_BLOCK_ERASE    = 8'hd8; // Block erase
	localparam logic [7:0] OP_CHIP_ERASE_A   = 8'hc7; // Chip erase, first code
	localparam logic [7:0] OP_CHIP_ERASE_B   = 8'h60; // Chip erase, second code
	localparam logic [7:0] OP_ENTER_OTP      = 8'h3a; // Enter one-time-programmable mode
	localparam logic [7:0] OP_READ_PLAIN     = 8'h03; // Plain read
	localparam logic [7:0] OP_READ_FAST      = 8'h0b; // Fast read
	localparam logic [7:0] OP_READ_DUAL_OUT  = 8'h3b; // Dual output read
	localparam logic [7:0] OP_READ_DUAL_IO   = 8'hbb; // Dual I/O read
	localparam logic [7:0] OP_READ_QUAD_IO   = 8'heb; // Quad I/O read

	// ****************************************************************
	// Status byte layout
	// ****************************************************************
	localparam int STAT_BUSY       = 0; // Busy flag
	localparam int STAT_WEL        = 1; // Write enable latch
	localparam int STAT_BP_LO      = 2; // Block protect bit zero
	localparam int STAT_BP_HI      = 5; // Block protect bit three
	localparam int STAT_PIN_DIS    = 6; // Protect/hold pin disable
	localparam int STAT_PROTECT    = 7; // Protect status register, OTP lock
	localparam logic [7:0] STATUS_RESET_VALUE = 8'h00; // Value after software reset

	// ****************************************************************
	// Frame lengths in bits
	// ****************************************************************
	localparam logic [4:0] OPCODE_BITS   = 5'h08; // Opcode complete
	localparam logic [4:0] DATA_END_BITS = 5'h10; // Opcode plus one data byte
	localparam logic [4:0] STEP_SINGLE   = 5'h01; // Bits per clock, one-bit mode
	localparam logic [4:0] STEP_QUAD     = 5'h04; // Bits per clock, four-bit mode

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLOCK_PERIOD_NS   = 20;    // System clock period
	localparam int RESET_RECOVERY_NS = 28000; // Worst reset latency after erase
	localparam int RECOVERY_CYCLES   = RESET_RECOVERY_NS / CLOCK_PERIOD_NS; // Rounded down

	// Kind of self-timed cycle in progress
	typedef enum logic [1:0] {
		CYC_NONE,
		CYC_STATUS,
		CYC_PROGRAM,
		CYC_ERASE
	} sfm_cycle_type;

endpackage

//--- sfm_sync.sv
// Two flip-flop synchroniser for slow level inputs
`timescale 1ns/1ns
`default_nettype none

module sfm_sync #(
	parameter int WIDTH      = 1,
	parameter logic RESET_LEVEL = 1'b0
) (
	input  wire logic             clock,
	input  wire logic             arst_n,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic [WIDTH-1:0] stage1; // Metastable catch, read only by stage2
		logic [WIDTH-1:0] stage2; // Settled copy
	} sfm_sync_type;

	sfm_sync_type state_q;
	sfm_sync_type state_d;

	// Refuse a zero width
	if (WIDTH < 1) begin : g_check
		$error("sfm_sync needs WIDTH of at least one");
	end

	// Shift the input through both stages
	always_comb begin
		state_d        = state_q;
		state_d.stage1 = din;
		state_d.stage2 = state_q.stage1;
	end

	// Register both stages
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= {2 * WIDTH{RESET_LEVEL}};
		end else begin
			state_q <= state_d;
		end
	end

	assign dout = state_q.stage2;

endmodule
`default_nettype wire

//--- sfm_ctrl_asserts.sv
// Checker of the flash control block ports
`timescale 1ns/1ns
`default_nettype none
module sfm_ctrl_asserts
	import sfm_pkg::*;
(
	input wire logic       clock,
	input wire logic       arst_n,
	input wire logic       serialClock,
	input wire logic       chipSelN,
	input wire logic [3:0] dqIn,
	input wire logic [3:0] dqOut,
	input wire logic [3:0] dqOe,
	input wire logic       enhanceActive,
	input wire logic       enhanceRelease,
	input wire logic       opStart,
	input wire logic [7:0] opCode,
	input wire logic       opAbort,
	input wire logic       quadMode,
	input wire logic       otpMode,
	input wire logic       deviceReady,
	input wire logic [7:0] statusByte
);
	// ****************************************************************
	// Properties
	// ****************************************************************
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	// Pins released outside a frame
	property p_oe_idle; chipSelN |-> dqOe == 4'h0; endproperty
	a_oe_idle: assert property (p_oe_idle) else $error("pins driven while deselected");
	// Driven width follows the mode
	property p_oe_width; (!chipSelN && dqOe != 4'h0) |-> dqOe == (quadMode ? 4'hf : 4'h2);
	endproperty
	a_oe_width: assert property (p_oe_width) else $error("wrong pin width");
	// Mode moves only after a finished frame
	property p_mode_framed; $changed(quadMode) |-> chipSelN && $past(chipSelN, 2); endproperty
	a_mode_framed: assert property (p_mode_framed) else $error("mode moved in frame");
	// Latch set only by a finished frame
	property p_latch_set; $rose(statusByte[STAT_WEL]) |-> $past(chipSelN, 2); endproperty
	a_latch_set: assert property (p_latch_set) else $error("latch set in frame");
	// No self-timed cycle without the latch
	property p_busy_latch; $rose(statusByte[STAT_BUSY]) |-> $past(statusByte[STAT_WEL]);
	endproperty
	a_busy_latch: assert property (p_busy_latch) else $error("cycle without latch");
	// Cycle end drops the latch
	property p_busy_end; $fell(statusByte[STAT_BUSY]) |-> ##[0:1] !statusByte[STAT_WEL];
	endproperty
	a_busy_end: assert property (p_busy_end) else $error("latch kept after cycle");
	// Abort comes with a cleared status and one-bit mode
	property p_abort; opAbort |-> ##[0:1] (statusByte == STATUS_RESET_VALUE && !quadMode);
	endproperty
	a_abort: assert property (p_abort) else $error("abort left status");
	// Plain read never launched in quad mode
	property p_quad_refuse; (opStart && opCode == OP_READ_PLAIN) |-> !quadMode; endproperty
	a_quad_refuse: assert property (p_quad_refuse) else $error("plain read in quad");
	// First exit in enhancement keeps quad mode; only a software reset may clear it
	property p_release; enhanceRelease |-> $stable(quadMode) ||
		(!quadMode && !otpMode && statusByte == STATUS_RESET_VALUE); endproperty
	a_release: assert property (p_release) else $error("quad left with release");
	// Recovery starts only with an abort
	property p_ready; $fell(deviceReady) |-> (opAbort || $past(opAbort)); endproperty
	a_ready: assert property (p_ready) else $error("recovery without abort");
	c_abort: cover property (opAbort);
	c_release: cover property (enhanceRelease);
	c_quad_exit: cover property ($fell(quadMode));
endmodule
bind sfm_ctrl sfm_ctrl_asserts i_chk (.clock(clock), .arst_n(arst_n),
	.serialClock(serialClock), .chipSelN(chipSelN), .dqIn(dqIn), .dqOut(dqOut),
	.dqOe(dqOe), .enhanceActive(enhanceActive), .enhanceRelease(enhanceRelease),
	.opStart(opStart), .opCode(opCode), .opAbort(opAbort), .quadMode(quadMode),
	.otpMode(otpMode), .deviceReady(deviceReady), .statusByte(statusByte));
`default_nettype wire

//--- sfm_host.sv
// Host model that frames commands on the link
`timescale 1ns/1ns
`default_nettype none
module sfm_host (
	output logic           serialClock, // Link clock, still outside frames
	output logic           chipSelN,    // Frame select, active low
	output logic      [3:0] dqIn,       // Data toward the device
	input  wire logic [3:0] dqOut       // Data from the device
);
	// ****************************************************************
	// Framing
	// ****************************************************************
	logic wp = 1'b1; // Protect pin level driven in one-bit mode
	// Idle link, protect pin high
	initial begin
		serialClock = 1'b0;
		chipSelN = 1'b1;
		dqIn = 4'h5;
	end
	// One frame, MSB first, answer gathered at rising edges
	task automatic frame(input logic [15:0] bits, input int nClk, input logic quad,
		output logic [7:0] rd);
		rd = 8'h00;
		chipSelN = 1'b0;
		#100;
		for (int i = 0; i < nClk; i++) begin
			// Nibble or single bit per clock
			dqIn = quad ? bits[15-4*i -: 4] : {~bits[15-i], wp, ~bits[15-i], bits[15-i]};
			#62 serialClock = 1'b1;
			rd = quad ? {rd[3:0], dqOut} : {rd[6:0], dqOut[1]};
			#63 serialClock = 1'b0;
		end
		#40 chipSelN = 1'b1;
		dqIn = {~dqIn[3], wp, ~dqIn[1:0]};
		#200;
	endtask
endmodule
`default_nettype wire

//--- testbench.sv
// Self-checking bench of the flash control block
`timescale 1ns/1ns
`default_nettype none
module testbench
	import sfm_pkg::*;
;
	logic       clock = 1'b0;         // System clock
	logic       arst_n = 1'b0;        // Reset, active low
	logic       enhanceActive = 1'b0; // Read engine in enhancement
	logic       serialClock, chipSelN;
	logic [3:0] dqIn, dqOut, dqOe;
	logic       enhanceRelease, opStart, opAbort, quadMode, otpMode, deviceReady;
	logic [7:0] opCode, statusByte, rd, r;
	logic       q;                    // Expected mode of the link
	int         seed = 9704;
	int         nMismatch, nTests, nStart, nRel, nAb, n0, w;
	logic [7:0] bad [4] = '{OP_READ_PLAIN, OP_READ_DUAL_OUT, OP_READ_DUAL_IO, OP_QUAD_PROGRAM};
	always #10 clock = ~clock;
	// Count launch, release and abort pulses
	always @(posedge clock) begin
		if (opStart === 1'b1) nStart++;
		if (enhanceRelease === 1'b1) nRel++;
		if (opAbort === 1'b1) nAb++;
	end
	sfm_host i_host (.serialClock(serialClock), .chipSelN(chipSelN), .dqIn(dqIn), .dqOut(dqOut));
	sfm_ctrl #(.STATUS_WRITE_CYCLES(400), .PROGRAM_CYCLES(3), .ERASE_CYCLES(3000),
		.STATUS_INIT(8'h00)) i_dut (.clock(clock), .arst_n(arst_n),
		.serialClock(serialClock), .chipSelN(chipSelN), .dqIn(dqIn), .dqOut(dqOut),
		.dqOe(dqOe), .enhanceActive(enhanceActive), .enhanceRelease(enhanceRelease),
		.opStart(opStart), .opCode(opCode), .opAbort(opAbort), .quadMode(quadMode),
		.otpMode(otpMode), .deviceReady(deviceReady), .statusByte(statusByte));
	// ****************************************************************
	// Tasks
	// ****************************************************************
	function automatic logic [7:0] expSt(input logic [7:0] d, input logic write_enable_latch, input logic bsy);
		return {d[7:2], write_enable_latch, bsy};
	endfunction
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		nTests++;
		if (seen !== exp) begin
			nMismatch++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic sc(input logic [7:0] op);
		i_host.frame({op, 8'h00}, q ? 2 : 8, q, rd);
	endtask
	task automatic wr(input logic [7:0] d);
		i_host.frame({OP_STATUS_WRITE, d}, q ? 4 : 16, q, rd);
	endtask
	task automatic rs;
		i_host.frame({OP_STATUS_READ, 8'h00}, q ? 4 : 16, q, rd);
	endtask
	// Poll busy with bounded status frames
	task automatic idle;
		for (int i = 0; i < 40; i++) begin
			rs();
			if (rd[STAT_BUSY] === 1'b0) return;
		end
		nMismatch++;
		endSim();
	endtask
	task automatic endSim;
		$display("checks=%0d mismatches=%0d", nTests, nMismatch);
		if (nMismatch == 0 && nTests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		repeat (100000) @(posedge clock);
		nMismatch++;
		endSim();
	end
	// ****************************************************************
	// Scenarios
	// ****************************************************************
	initial begin
		q = 1'b0;
		repeat (16) @(posedge clock);
		@(negedge clock) arst_n = 1'b1;
		repeat (4) @(posedge clock);
		chk(statusByte, 8'h00);
		i_host.frame({OP_LATCH_SET, 8'h00}, 4, 1'b0, rd);
		rs();
		chk(rd, 8'h00);
		sc(OP_LATCH_SET);
		chk(statusByte, expSt(8'h00, 1'b1, 1'b0));
		rs();
		chk(rd, 8'h02);
		sc(OP_LATCH_CLEAR);
		wr(8'h3c);
		chk(statusByte, 8'h00);
		$display("test latch done");
		for (int k = 0; k < 3; k++) begin
			r = $random(seed);
			if (k == 2) r[STAT_BP_LO] = 1'b1;
			sc(OP_LATCH_SET);
			wr(r);
			rs();
			chk(rd, expSt(r, 1'b1, 1'b1));
			idle();
			chk(statusByte, expSt(r, 1'b0, 1'b0));
		end
		n0 = nStart;
		sc(OP_LATCH_SET);
		sc(OP_SECTOR_ERASE);
		sc(OP_CHIP_ERASE_A);
		chk(8'(nStart - n0), 8'h00);
		sc(OP_LATCH_SET);
		wr(8'h00);
		idle();
		$display("test status write done");
		sc(OP_LATCH_SET);
		sc(OP_SECTOR_ERASE);
		chk(opCode, OP_SECTOR_ERASE);
		chk(8'(nStart - n0), 8'h01);
		sc(OP_RESET_ARM);
		sc(OP_RESET_FIRE);
		chk(statusByte, STATUS_RESET_VALUE);
		chk(8'(nAb), 8'h01);
		for (w = 0; w < 1500 && deviceReady !== 1'b1; w++) @(posedge clock);
		chk({7'h0, w > 1350 && w < 1500}, 8'h01);
		sc(OP_RESET_ARM);
		sc(OP_LATCH_SET);
		sc(OP_RESET_FIRE);
		chk(statusByte, 8'h02);
		sc(OP_RESET_ARM);
		sc(OP_RESET_FIRE);
		chk(statusByte, 8'h00);
		$display("test reset done");
		sc(OP_LATCH_SET);
		wr(8'h80);
		idle();
		i_host.wp = 1'b0;
		sc(OP_LATCH_SET);
		wr(8'h00);
		chk(statusByte, 8'h82);
		sc(OP_RESET_ARM);
		sc(OP_RESET_FIRE);
		sc(OP_LATCH_SET);
		wr(8'hc0);
		idle();
		sc(OP_LATCH_SET);
		wr(8'hc4);
		idle();
		chk(statusByte, 8'hc4);
		i_host.wp = 1'b1;
		sc(OP_RESET_ARM);
		sc(OP_RESET_FIRE);
		$display("test protect done");
		sc(OP_READ_PLAIN);
		sc(OP_ENTER_OTP);
		sc(OP_LATCH_SET);
		wr(8'h00);
		idle();
		chk({otpMode, statusByte[7:1]}, 8'hc0);
		sc(OP_LATCH_CLEAR);
		chk({7'h0, otpMode}, 8'h00);
		sc(OP_RESET_ARM);
		sc(OP_RESET_FIRE);
		sc(OP_QUAD_EXIT);
		chk({7'h0, quadMode}, 8'h00);
		sc(OP_ENTER_QUAD);
		q = 1'b1;
		chk({7'h0, quadMode}, 8'h01);
		n0 = nStart;
		sc(OP_LATCH_SET);
		foreach (bad[i]) sc(bad[i]);
		sc(OP_READ_FAST);
		chk(8'(nStart - n0), 8'h01);
		rs();
		chk(rd, 8'h02);
		@(negedge clock) enhanceActive = 1'b1;
		n0 = nRel;
		sc(OP_QUAD_EXIT);
		chk({7'(nRel - n0), quadMode}, 8'h03);
		@(negedge clock) enhanceActive = 1'b0;
		sc(OP_QUAD_EXIT);
		q = 1'b0;
		chk({7'h0, quadMode}, 8'h00);
		sc(OP_ENTER_QUAD);
		q = 1'b1;
		sc(OP_RESET_ARM);
		sc(OP_RESET_FIRE);
		q = 1'b0;
		sc(OP_RESET_ARM);
		sc(OP_RESET_FIRE);
		chk({quadMode, statusByte[6:0]}, 8'h00);
		$display("test quad done");
		endSim();
	end
endmodule
`default_nettype wire
